//--- hdl/abc_top.sv
// address break comparator: register file on axi4-lite, bus match logic, interrupt and exception timing
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps

module abc_top (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic cpu_cyc, // a cpu bus cycle is on the buses this clock
	input wire logic cpu_fetch, // cycle is the first byte of an executed instruction
	input wire logic cpu_rd, // cycle is a cpu data read
	input wire logic cpu_wr, // cycle is a cpu data write
	input wire logic cpu_word, // word access (else byte)
	input wire logic [1:0] cpu_space, // memory, 8-bit io or 16-bit io space
	input wire logic [23:0] cpu_addr, // internal address bus
	input wire logic [15:0] cpu_data, // internal data bus, both lanes
	input wire logic cpu_rte_done, // pulse: return-from-exception executed
	input wire logic cpu_insn_done, // pulse: an instruction completed
	input wire logic cpu_break_ack, // pulse: cpu accepted the break request
	output logic break_req, // break interrupt request to cpu
	output logic break_exc_start, // pulse: start break exception handling
	output logic rte_irq_mask, // interrupts masked after return-from-exception
	output logic irq // system interrupt, level
);
	typedef struct packed {
		logic [7:0] ctrl;
		logic flag;
		logic en;
		logic armed;
		logic [23:0] brka;
		logic [15:0] brkd;
		logic [1:0] ists;
		logic [1:0] ien;
		logic rte_mask;
		logic pend;
		logic exc;
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] rd_addr;
	} abc_state_t;

	abc_state_t st_ff;
	abc_state_t nxt_st;

	logic [1:0] csel;
	logic [2:0] acmp;
	logic [1:0] dcmp;
	logic cyc_ok;
	logic [23:0] amask;
	logic addr_ok;
	logic spec_reg;
	logic lane_hi;
	logic lane_lo;
	logic data_ok;
	logic match_now;
	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	logic wr_go;
	logic [31:0] rd_word;
	logic rd_hit;
	logic wr_hit;

	assign csel = st_ff.ctrl[abc_pkg::CTRL_CSEL_LSB +: 2];
	assign acmp = st_ff.ctrl[abc_pkg::CTRL_ACMP_LSB +: 3];
	assign dcmp = st_ff.ctrl[abc_pkg::CTRL_DCMP_LSB +: 2];

	// cycle type qualification
	always_comb begin
		unique case (csel)
			abc_pkg::CSEL_FETCH: cyc_ok = cpu_fetch;
			abc_pkg::CSEL_READ: cyc_ok = cpu_rd;
			abc_pkg::CSEL_WRITE: cyc_ok = cpu_wr;
			abc_pkg::CSEL_RDWR: cyc_ok = cpu_rd | cpu_wr;
		endcase
	end

	// address compare width: keep the upper bits, drop 4 per code step; prohibited codes compare nothing
	always_comb begin
		if (acmp > abc_pkg::ACMP_MAX) begin
			amask = 24'h000000;
		end else begin
			amask = 24'hFFFFFF << (abc_pkg::ACMP_STEP * int'(acmp));
		end
	end
	assign addr_ok = ((cpu_addr ^ st_ff.brka) & amask) == 24'h000000;

	// which byte lane carries the data of this access
	assign spec_reg = (cpu_addr >= abc_pkg::SPEC_A_LO && cpu_addr <= abc_pkg::SPEC_A_HI) ||
		(cpu_addr >= abc_pkg::SPEC_B_LO && cpu_addr <= abc_pkg::SPEC_B_HI);
	always_comb begin
		lane_hi = 1'b0;
		lane_lo = 1'b0;
		unique case (cpu_space)
			abc_pkg::SPACE_IO8: begin
				lane_hi = 1'b1;
			end
			abc_pkg::SPACE_IO16: begin
				lane_hi = cpu_word ? ~cpu_addr[0] : spec_reg;
				lane_lo = cpu_word & cpu_addr[0];
			end
			default: begin
				lane_hi = ~cpu_word | ~cpu_addr[0];
				lane_lo = cpu_word & cpu_addr[0];
			end
		endcase
	end

	// data compare; fetch breaks never compare data
	always_comb begin
		if (csel == abc_pkg::CSEL_FETCH) begin
			data_ok = 1'b1;
		end else begin
			unique case (dcmp)
				abc_pkg::DCMP_NONE: data_ok = 1'b1;
				abc_pkg::DCMP_LOW: data_ok = lane_lo && cpu_data[7:0] == st_ff.brkd[7:0];
				abc_pkg::DCMP_HIGH: data_ok = lane_hi && cpu_data[15:8] == st_ff.brkd[15:8];
				abc_pkg::DCMP_BOTH: data_ok = cpu_data == st_ff.brkd;
			endcase
		end
	end

	assign match_now = cpu_cyc & cyc_ok & addr_ok & data_ok;

	// bus handshakes: one write and one read under way at a time
	assign s_axi_awready = ~st_ff.aw_have & ~st_ff.bvalid;
	assign s_axi_wready = ~st_ff.w_have & ~st_ff.bvalid;
	assign s_axi_arready = ~st_ff.rvalid;
	assign aw_hs = s_axi_awvalid & s_axi_awready;
	assign w_hs = s_axi_wvalid & s_axi_wready;
	assign ar_hs = s_axi_arvalid & s_axi_arready;
	assign wr_go = st_ff.aw_have & st_ff.w_have & ~st_ff.bvalid;

	// read mux; write-only clear register reads zero
	always_comb begin
		rd_word = 32'h00000000;
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			abc_pkg::ADDR_CTRL: rd_word[7:0] = st_ff.ctrl;
			abc_pkg::ADDR_STAT: rd_word[7:0] = {st_ff.flag, st_ff.en, abc_pkg::STAT_RSVD};
			abc_pkg::ADDR_BRKA: rd_word[23:0] = st_ff.brka;
			abc_pkg::ADDR_BRKD: rd_word[15:0] = st_ff.brkd;
			abc_pkg::ADDR_ISTS: rd_word[1:0] = st_ff.ists;
			abc_pkg::ADDR_ICLR: rd_word = 32'h00000000;
			abc_pkg::ADDR_IEN: rd_word[1:0] = st_ff.ien;
			default: rd_hit = 1'b0;
		endcase
	end

	always_comb begin
		unique case (st_ff.aw_addr)
			abc_pkg::ADDR_CTRL, abc_pkg::ADDR_STAT, abc_pkg::ADDR_BRKA, abc_pkg::ADDR_BRKD,
			abc_pkg::ADDR_ISTS, abc_pkg::ADDR_ICLR, abc_pkg::ADDR_IEN: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// next state of the whole block
	always_comb begin
		nxt_st = st_ff;
		nxt_st.exc = 1'b0;
		// write channel capture
		if (aw_hs) begin
			nxt_st.aw_have = 1'b1;
			nxt_st.aw_addr = s_axi_awaddr;
		end
		if (w_hs) begin
			nxt_st.w_have = 1'b1;
			nxt_st.w_data = s_axi_wdata;
			nxt_st.w_strb = s_axi_wstrb;
		end
		if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid = 1'b0;
		end
		// register writes once both halves are held
		if (wr_go) begin
			nxt_st.aw_have = 1'b0;
			nxt_st.w_have = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = wr_hit ? abc_pkg::RESP_OKAY : abc_pkg::RESP_SLVERR;
			if (st_ff.aw_addr == abc_pkg::ADDR_CTRL && st_ff.w_strb[0]) begin
				nxt_st.ctrl = st_ff.w_data[7:0];
				if (st_ff.w_data[abc_pkg::CTRL_ACMP_LSB +: 3] > abc_pkg::ACMP_MAX) begin
					nxt_st.ists[abc_pkg::IRQ_BIT_BADW] = 1'b1;
				end
			end
			if (st_ff.aw_addr == abc_pkg::ADDR_STAT && st_ff.w_strb[0]) begin
				nxt_st.en = st_ff.w_data[abc_pkg::STAT_EN_BIT];
				nxt_st.armed = 1'b0;
				if (st_ff.armed && !st_ff.w_data[abc_pkg::STAT_FLAG_BIT]) begin
					nxt_st.flag = 1'b0;
				end
			end
			if (st_ff.aw_addr == abc_pkg::ADDR_BRKA) begin
				for (int i = 0; i < 3; i++) begin
					if (st_ff.w_strb[i]) begin
						nxt_st.brka[8*i +: 8] = st_ff.w_data[8*i +: 8];
					end
				end
			end
			if (st_ff.aw_addr == abc_pkg::ADDR_BRKD) begin
				for (int i = 0; i < 2; i++) begin
					if (st_ff.w_strb[i]) begin
						nxt_st.brkd[8*i +: 8] = st_ff.w_data[8*i +: 8];
					end
				end
			end
			if (st_ff.aw_addr == abc_pkg::ADDR_ICLR && st_ff.w_strb[0]) begin
				nxt_st.ists = st_ff.ists & ~st_ff.w_data[1:0];
			end
			if (st_ff.aw_addr == abc_pkg::ADDR_IEN && st_ff.w_strb[0]) begin
				nxt_st.ien = st_ff.w_data[1:0];
			end
		end
		// read channel
		if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid = 1'b0;
		end
		if (ar_hs) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata = rd_word;
			nxt_st.rresp = rd_hit ? abc_pkg::RESP_OKAY : abc_pkg::RESP_SLVERR;
			nxt_st.rd_addr = s_axi_araddr;
			if (s_axi_araddr == abc_pkg::ADDR_STAT && st_ff.flag) begin
				nxt_st.armed = 1'b1;
			end
		end
		// a match sets the flag and wins over a clear in the same cycle
		if (match_now) begin
			nxt_st.flag = 1'b1;
			nxt_st.ists[abc_pkg::IRQ_BIT_MATCH] = 1'b1;
		end
		// masking window after return-from-exception
		if (cpu_insn_done) begin
			nxt_st.rte_mask = 1'b0;
		end
		if (cpu_rte_done && !st_ff.ctrl[abc_pkg::CTRL_UNMASK_BIT]) begin
			nxt_st.rte_mask = 1'b1;
		end
		// accepted request waits for the running instruction to end
		if (cpu_break_ack && break_req) begin
			nxt_st.pend = 1'b1;
		end
		if ((st_ff.pend || (cpu_break_ack && break_req)) && cpu_insn_done) begin
			nxt_st.pend = 1'b0;
			nxt_st.exc = 1'b1;
		end
	end

	// state registers; break data is not touched by reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
			st_ff.ctrl <= abc_pkg::CTRL_RESET;
			st_ff.brka <= abc_pkg::BRKA_RESET;
			st_ff.brkd <= st_ff.brkd;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs; the cpu global mask bit plays no part in the request
	assign break_req = st_ff.flag & st_ff.en & ~st_ff.rte_mask;
	assign break_exc_start = st_ff.exc;
	assign rte_irq_mask = st_ff.rte_mask;
	assign irq = |(st_ff.ists & st_ff.ien);
	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_rvalid = st_ff.rvalid;
	assign s_axi_rdata = st_ff.rdata;
	assign s_axi_rresp = st_ff.rresp;

	// checks
	sequence s_rte_masked;
		cpu_rte_done && !st_ff.ctrl[abc_pkg::CTRL_UNMASK_BIT] && !cpu_insn_done;
	endsequence
	sequence s_stat_read;
		s_axi_rvalid && st_ff.rd_addr == abc_pkg::ADDR_STAT;
	endsequence

	AST_MATCH_SETS_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
		match_now |=> st_ff.flag)
		else $error("break flag not set after a match");
	AST_FLAG_NEXT_CYCLE: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(st_ff.flag) |-> $past(match_now))
		else $error("break flag rose without a match");
	AST_CLEAR_NEEDS_READ: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(st_ff.flag) |-> $past(st_ff.armed) && $past(wr_go) && $past(st_ff.aw_addr) == abc_pkg::ADDR_STAT)
		else $error("break flag cleared without prior read of one");
	AST_REQ_GATED: assert property (@(posedge aclk) disable iff (!aresetn)
		break_req |-> st_ff.flag && st_ff.en)
		else $error("break request without flag and enable");
	AST_RSVD_ONES: assert property (@(posedge aclk) disable iff (!aresetn)
		s_stat_read |-> s_axi_rdata[5:0] == 6'h3F)
		else $error("reserved status bits not read as ones");
	AST_RTE_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
		s_rte_masked |=> rte_irq_mask && !break_req)
		else $error("interrupt not masked after return-from-exception");
	AST_EXC_AFTER_INSN: assert property (@(posedge aclk) disable iff (!aresetn)
		break_exc_start |-> $past(cpu_insn_done))
		else $error("break exception started before instruction end");
	AST_ADDR_RESET: assert property (@(posedge aclk)
		!aresetn |=> st_ff.brka == abc_pkg::BRKA_RESET)
		else $error("break address not reset");
	AST_IO16_BYTE: assert property (@(posedge aclk) disable iff (!aresetn)
		cpu_cyc && cpu_space == abc_pkg::SPACE_IO16 && !cpu_word && !spec_reg && dcmp == abc_pkg::DCMP_HIGH
		&& csel != abc_pkg::CSEL_FETCH |-> !match_now)
		else $error("byte access to plain 16-bit io matched on data");
	AST_IO8_UPPER: assert property (@(posedge aclk) disable iff (!aresetn)
		cpu_cyc && cpu_space == abc_pkg::SPACE_IO8 |-> lane_hi && !lane_lo)
		else $error("8-bit io access not on upper lane");
	AST_REQ_SETS: assert property (@(posedge aclk) disable iff (!aresetn)
		st_ff.flag && st_ff.en && !rte_irq_mask |-> break_req)
		else $error("break request missing while flag and enable are set");
	AST_FLAG_HOLDS: assert property (@(posedge aclk) disable iff (!aresetn)
		st_ff.flag && !(wr_go && st_ff.armed && st_ff.aw_addr == abc_pkg::ADDR_STAT) |=> st_ff.flag)
		else $error("break flag lost without a clearing write");
	AST_RTE_RELEASE: assert property (@(posedge aclk) disable iff (!aresetn)
		rte_irq_mask && cpu_insn_done && !cpu_rte_done |=> !rte_irq_mask)
		else $error("mask kept after one instruction");
	AST_RTE_NO_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
		cpu_rte_done && st_ff.ctrl[abc_pkg::CTRL_UNMASK_BIT] && !rte_irq_mask |=> !rte_irq_mask)
		else $error("interrupt masked although unmask bit is set");
	AST_EXC_FOLLOWS_ACK: assert property (@(posedge aclk) disable iff (!aresetn)
		cpu_break_ack && break_req && cpu_insn_done |=> break_exc_start)
		else $error("break exception not started at instruction end");
	AST_FETCH_NO_DATA: assert property (@(posedge aclk) disable iff (!aresetn)
		csel == abc_pkg::CSEL_FETCH |-> data_ok)
		else $error("fetch break compared data");
endmodule

//--- include/abc_pkg.sv
// package: register map, field positions, reset values and bus constants of the address break comparator
package abc_pkg;
	// register byte addresses on the control bus
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_BRKA = 8'h08;
	localparam logic [7:0] ADDR_BRKD = 8'h0C;
	localparam logic [7:0] ADDR_ISTS = 8'h10;
	localparam logic [7:0] ADDR_ICLR = 8'h14;
	localparam logic [7:0] ADDR_IEN = 8'h18;
	// condition control fields
	localparam int CTRL_UNMASK_BIT = 7;
	localparam int CTRL_CSEL_LSB = 5;
	localparam int CTRL_ACMP_LSB = 2;
	localparam int CTRL_DCMP_LSB = 0;
	localparam logic [7:0] CTRL_RESET = 8'h80;
	// status / enable fields
	localparam int STAT_FLAG_BIT = 7;
	localparam int STAT_EN_BIT = 6;
	localparam logic [5:0] STAT_RSVD = 6'h3F;
	// break address reset value
	localparam logic [23:0] BRKA_RESET = 24'h0FFFFF;
	// cycle select codes
	localparam logic [1:0] CSEL_FETCH = 2'h0;
	localparam logic [1:0] CSEL_READ = 2'h1;
	localparam logic [1:0] CSEL_WRITE = 2'h2;
	localparam logic [1:0] CSEL_RDWR = 2'h3;
	// data compare codes
	localparam logic [1:0] DCMP_NONE = 2'h0;
	localparam logic [1:0] DCMP_LOW = 2'h1;
	localparam logic [1:0] DCMP_HIGH = 2'h2;
	localparam logic [1:0] DCMP_BOTH = 2'h3;
	// largest legal address compare code, step of the width in bits
	localparam logic [2:0] ACMP_MAX = 3'h5;
	localparam int ACMP_STEP = 4;
	// address space kinds of a cpu cycle
	localparam logic [1:0] SPACE_MEM = 2'h0;
	localparam logic [1:0] SPACE_IO8 = 2'h1;
	localparam logic [1:0] SPACE_IO16 = 2'h2;
	// special 16-bit registers that allow byte access
	localparam logic [23:0] SPEC_A_LO = 24'hFFFF96;
	localparam logic [23:0] SPEC_A_HI = 24'hFFFF97;
	localparam logic [23:0] SPEC_B_LO = 24'hFFFFB8;
	localparam logic [23:0] SPEC_B_HI = 24'hFFFFBB;
	// interrupt event bits
	localparam int IRQ_BIT_MATCH = 0;
	localparam int IRQ_BIT_BADW = 1;
	localparam int IRQ_W = 2;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- sim/abc_cpu_model.sv
// cpu bus model: one bus cycle per request, scrambled idle buses, accepts break requests
`timescale 1ns/1ps
module abc_cpu_model (
	input wire logic aclk, // system clock
	input wire logic aresetn, // reset, active low
	input wire logic go, // bench asks for one bus cycle
	input wire logic [1:0] kind, // 0 fetch, 1 read, 2 write
	input wire logic word, // word access
	input wire logic [1:0] space, // address space
	input wire logic [23:0] addr, // cycle address
	input wire logic [15:0] data, // cycle data
	input wire logic rte_go, // bench asks for a return-from-exception
	input wire logic break_req, // break request from the block
	output logic cpu_cyc, // bus cycle present
	output logic cpu_fetch, // first instruction byte
	output logic cpu_rd, // data read
	output logic cpu_wr, // data write
	output logic cpu_word, // word access
	output logic [1:0] cpu_space, // address space
	output logic [23:0] cpu_addr, // address bus
	output logic [15:0] cpu_data, // data bus
	output logic cpu_rte_done, // return executed
	output logic cpu_insn_done, // instruction completed
	output logic cpu_break_ack // request accepted
);
	logic [1:0] cnt_ff;
	// buses toggle when idle so a stale value never matches by chance
	always_ff @(posedge aclk) begin
		cpu_cyc <= go;
		cpu_fetch <= go && kind == 2'h0;
		cpu_rd <= go && kind == 2'h1;
		cpu_wr <= go && kind == 2'h2;
		cpu_word <= word;
		cpu_space <= space;
		cpu_addr <= go ? addr : (aresetn ? ~cpu_addr : 24'h5A5A5A);
		cpu_data <= go ? data : (aresetn ? ~cpu_data : 16'hA5A5);
		cpu_rte_done <= rte_go;
		cnt_ff <= aresetn ? cnt_ff + 2'h1 : 2'h0;
		cpu_insn_done <= cnt_ff == 2'h3; // an instruction ends every fourth clock
		cpu_break_ack <= aresetn && break_req && !cpu_break_ack;
	end
endmodule

//--- sim/abc_top_tb.sv
// testbench of the address break comparator
`timescale 1ns/1ps
module abc_top_tb;
	logic aclk, aresetn, awready, wready, bvalid, arready, rvalid, cyc, fetch, rd, wr_c, word_o, rte_done;
	logic insn_done, ack, break_req, exc, rte_mask, irq, ea;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, go = 1'b0, word = 1'b0;
	logic rte_go = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, c;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic [1:0] bresp, rresp, r, space_o, kind = 2'h0, space = 2'h0;
	logic [23:0] addr = 24'h0, addr_o, ba, a;
	logic [15:0] data = 16'h0, data_o, bd, d;
	int bad_count = 0, compares = 0, n_exc = 0, seed, i;
	abc_top i_abc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpu_cyc(cyc), .cpu_fetch(fetch), .cpu_rd(rd), .cpu_wr(wr_c),
		.cpu_word(word_o), .cpu_space(space_o), .cpu_addr(addr_o), .cpu_data(data_o), .cpu_rte_done(rte_done),
		.cpu_insn_done(insn_done), .cpu_break_ack(ack), .break_req(break_req), .break_exc_start(exc),
		.rte_irq_mask(rte_mask), .irq(irq));
	abc_cpu_model i_abc_cpu_model (.aclk(aclk), .aresetn(aresetn), .go(go), .kind(kind), .word(word), .space(space),
		.addr(addr), .data(data), .rte_go(rte_go), .break_req(break_req), .cpu_cyc(cyc), .cpu_fetch(fetch),
		.cpu_rd(rd), .cpu_wr(wr_c), .cpu_word(word_o), .cpu_space(space_o), .cpu_addr(addr_o), .cpu_data(data_o),
		.cpu_rte_done(rte_done), .cpu_insn_done(insn_done), .cpu_break_ack(ack));
	// clock and exception pulse counter
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	always @(posedge aclk) if (exc === 1'b1) n_exc <= n_exc + 1;
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask
	task automatic hang(input string m);
		bad_count++;
		$display("unexpected at %0t: %s hangs", $time, m);
		end_of_test();
	endtask
	// bus write: both halves offered together, each released when taken
	task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
		int n;
		logic ta, tw, tb;
		@(posedge aclk);
		awaddr <= ad;
		wdata <= dt;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		tb = 1'b0;
		for (n = 0; n < 50 && !tb; n++) begin
			@(negedge aclk);
			ta = awvalid && awready === 1'b1;
			tw = wvalid && wready === 1'b1;
			tb = bvalid === 1'b1;
			r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
		end
		if (!tb) hang("write");
	endtask
	// bus read: data and response sampled at the falling edge before the handshake edge
	task automatic rdv(input logic [7:0] ad);
		int n;
		logic ta, tb;
		@(posedge aclk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		tb = 1'b0;
		for (n = 0; n < 50 && !tb; n++) begin
			@(negedge aclk);
			ta = arvalid && arready === 1'b1;
			tb = rvalid === 1'b1;
			v = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tb) rready <= 1'b0;
		end
		if (!tb) hang("read");
	endtask
	task automatic rc(input logic [7:0] ad, input logic [31:0] e, input string m);
		rdv(ad);
		@(negedge aclk);
		chk(v, e, m);
		chk(r, 32'h0, "read response");
	endtask
	// expected break flag for one cpu cycle under a given setup
	function automatic logic hit(input logic [7:0] cc, input logic [23:0] b, input logic [15:0] bdt, input logic [1:0] k,
		input logic w, input logic [1:0] s, input logic [23:0] ad, input logic [15:0] dt);
		int sh;
		logic typ, up, ok;
		sh = cc[4:2] * 4;
		typ = cc[6:5] == 2'h0 ? k == 2'h0 : (cc[5] && k == 2'h1) || (cc[6] && k == 2'h2);
		up = !w || s == 2'h1 || !ad[0];
		ok = s != 2'h2 || w || ad[23:1] == 23'h7FFFCB || ad[23:2] == 22'h3FFFEE;
		if ((b >> sh) != (ad >> sh) || !typ) return 1'b0;
		if (cc[6:5] == 2'h0 || cc[1:0] == 2'h0) return 1'b1;
		if (cc[1:0] == 2'h3) return dt == bdt;
		return ok && (cc[0] ? !up && dt[7:0] == bdt[7:0] : up && dt[15:8] == bdt[15:8]);
	endfunction
	task automatic cycle(input logic [1:0] k, input logic w, input logic [1:0] s, input logic [23:0] ad,
		input logic [15:0] dt);
		@(posedge aclk);
		kind <= k;
		word <= w;
		space <= s;
		addr <= ad;
		data <= dt;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask
	// program a condition, run one cycle, compare flag and interrupt, clean up
	task automatic one(input logic [7:0] cc, input logic [23:0] b, input logic [15:0] bdt, input logic [1:0] k,
		input logic w, input logic [1:0] s, input logic [23:0] ad, input logic [15:0] dt);
		ea = hit(cc, b, bdt, k, w, s, ad, dt);
		wr(8'h00, {24'h0, cc});
		wr(8'h08, {8'h0, b});
		wr(8'h0C, {16'h0, bdt});
		cycle(k, w, s, ad, dt);
		rc(8'h04, {24'h0, ea, 7'h3F}, "flag");
		chk(irq, ea, "irq");
		wr(8'h04, 32'h0);
		wr(8'h14, 32'h1);
	endtask
	task automatic return_from_exception(input logic e);
		int hi;
		@(posedge aclk);
		rte_go <= 1'b1;
		@(posedge aclk);
		rte_go <= 1'b0;
		hi = 0;
		repeat (8) begin
			@(negedge aclk);
			hi = hi + (rte_mask === 1'b1);
		end
		chk(hi > 0, e, "mask after return");
		chk(rte_mask, 1'b0, "mask released");
	endtask
	// main sequence
	initial begin
		seed = 32'h6302FEF9;
		aresetn = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rc(8'h00, 32'h80, "ctrl reset");
		rc(8'h04, 32'h3F, "status reset");
		rc(8'h08, 32'h0FFFFF, "address reset");
		wr(8'h04, 32'h00);
		rc(8'h04, 32'h3F, "reserved");
		rdv(8'h1C);
		chk(r, 2'h2, "unmapped");
		wr(8'h1C, 32'h5);
		chk(r, 2'h2, "unmapped write");
		wr(8'h18, 32'h1);
		chk(r, 2'h0, "write response");
		$display("test registers done");
		one(8'h80, 24'h001234, 16'h0, 2'h0, 1'b1, 2'h0, 24'h001234, 16'h0);
		one(8'hA2, 24'h0A5001, 16'hA500, 2'h1, 1'b0, 2'h0, 24'h0A5001, 16'hA5FF);
		one(8'hC2, 24'hFFFF90, 16'h3C00, 2'h2, 1'b0, 2'h2, 24'hFFFF90, 16'h3C00);
		one(8'hC2, 24'hFFFFB9, 16'h3C00, 2'h2, 1'b0, 2'h2, 24'hFFFFB9, 16'h3C00);
		one(8'hA2, 24'hFFF001, 16'h7700, 2'h1, 1'b1, 2'h1, 24'hFFF001, 16'h7711);
		one(8'hA1, 24'h000201, 16'h0055, 2'h1, 1'b1, 2'h0, 24'h000201, 16'h6655);
		one(8'hF4, 24'h812345, 16'h0, 2'h2, 1'b1, 2'h0, 24'h8EDCBA, 16'h0);
		one(8'hE0, 24'h812345, 16'h0, 2'h2, 1'b1, 2'h0, 24'h812344, 16'h0);
		one(8'hE3, 24'h0, 16'h1234, 2'h1, 1'b1, 2'h0, 24'h0, 16'h1334);
		for (i = 0; i < 40; i++) begin
			c = {1'b1, 2'($random(seed)), 3'({$random(seed)} % 6), 2'($random(seed))};
			ba = 24'($random(seed));
			bd = 16'($random(seed));
			a = ($random(seed) & 1) ? ba : ba ^ (24'h1 << ({$random(seed)} % 24));
			d = ($random(seed) & 1) ? bd : 16'($random(seed));
			one(c, ba, bd, 2'({$random(seed)} % 3), 1'($random(seed)), 2'({$random(seed)} % 3), a, d);
		end
		$display("test matching done");
		wr(8'h08, 32'h000100);
		wr(8'h00, 32'h80);
		cycle(2'h0, 1'b1, 2'h0, 24'h000100, 16'h0);
		wr(8'h04, 32'h40);
		rc(8'h04, 32'hFF, "flag kept");
		chk(break_req, 1'b1, "request");
		repeat (8) @(posedge aclk);
		chk(n_exc > 0, 1'b1, "exception start");
		wr(8'h04, 32'h40);
		rc(8'h04, 32'h7F, "flag cleared");
		chk(break_req, 1'b0, "request dropped");
		wr(8'h04, 32'h0);
		wr(8'h14, 32'h1);
		$display("test clearing done");
		wr(8'h00, 32'h98);
		rc(8'h10, 32'h2, "bad width event");
		chk(irq, 1'b0, "masked event");
		wr(8'h14, 32'h2);
		rc(8'h10, 32'h0, "event cleared");
		$display("test events done");
		wr(8'h00, 32'h00);
		return_from_exception(1'b1);
		wr(8'h00, 32'h80);
		return_from_exception(1'b0);
		$display("test return done");
		wr(8'h0C, 32'h5AC3);
		wr(8'h08, 32'h123456);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rc(8'h08, 32'h0FFFFF, "address reset again");
		rc(8'h0C, 32'h5AC3, "data kept");
		rc(8'h00, 32'h80, "ctrl reset again");
		$display("test reset done");
		end_of_test();
	end
endmodule
